// [ltmc_pkg.sv]
// ltmc_pkg: constants and types of the lin transceiver mode controller
// assumes one 250 MHz clock and a byte-wide register port
package ltmc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LTMC_CTRL_OFS   = 8'h21;
  localparam logic [7:0] LTMC_STAT_OFS   = 8'h24;
  localparam logic [7:0] LTMC_WAKE_OFS   = 8'h25;
  localparam logic [7:0] LTMC_CTRL_RST   = 8'h01;
  localparam logic [7:0] LTMC_STAT_RST   = 8'h00;
  localparam int         LTMC_MODE_LSB   = 0;
  localparam int         LTMC_TXTO_BIT   = 1;
  localparam int         LTMC_READY_BIT  = 0;
  localparam int         LTMC_WKEN_BIT   = 0;
  localparam int         LTMC_WKFL_BIT   = 1;
  localparam logic [1:0] LTMC_SEL_STBY   = 2'h1;
  localparam logic [1:0] LTMC_SEL_NORM   = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int LTMC_CLK_MHZ   = 250;
  localparam int LTMC_TBUS_NS   = 30000;
  localparam int LTMC_TXTO_NS   = 20000;
  localparam int LTMC_TBUS_CYC  = (LTMC_TBUS_NS * LTMC_CLK_MHZ + 999) / 1000;
  localparam int LTMC_TXTO_CYC  = (LTMC_TXTO_NS * LTMC_CLK_MHZ + 999) / 1000;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LTMC_UNPOWERED,
    LTMC_STANDBY,
    LTMC_NORMAL
  } ltmc_state_t;

  typedef enum logic [1:0] {
    LTMC_W_IDLE,
    LTMC_W_TIMING,
    LTMC_W_ARMED
  } ltmc_wake_t;

  typedef struct packed {
    logic vs_above_pwron;
    logic vs_below_pwroff;
    logic vs_uv;
    logic vcc_uv;
    logic overtemp;
    logic chip_normal;
  } ltmc_supply_t;

endpackage

// [ltmc_core.sv]
// ltmc_core: lin transceiver mode control, wake detection and status
// assumes all inputs synchronous to clock; bus comparators are analog side
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module ltmc_core
  import ltmc_pkg::*;
#(
  parameter int TBUS_CYC = LTMC_TBUS_CYC,
  parameter int TXTO_CYC = LTMC_TXTO_CYC
)
(
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [7:0]   reg_addr,
  input  wire logic [7:0]   reg_wdata,
  input  wire logic         reg_wr,
  input  wire logic         reg_rd,
  output logic      [7:0]   reg_rdata,
  input  wire ltmc_supply_t supply,
  input  wire logic         bus_below_prewake,
  input  wire logic         bus_rx_level,
  input  wire logic         txd_in,
  output logic              rxd_out,
  output logic              lin_drive_dominant,
  output logic              termination_en,
  output logic              strong_pullup_en,
  output logic              wake_rx_en,
  output logic              transceiver_normal
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  generate
    if (TBUS_CYC < 1 || TXTO_CYC < 1)
    begin : g_bad_param
      $error("ltmc_core: cycle counts must be at least one");
    end
  endgenerate

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [1:0]  lin_mode_select_q;
  logic        bus_wake_enable_q;
  logic        bus_wake_flag_q;
  logic        bus_wake_flag_d;
  logic        tx_timeout_flag_q;
  logic        transceiver_ready_flag_q;
  logic [7:0]  rdata_q;
  ltmc_state_t state_q;
  ltmc_state_t state_d;
  ltmc_wake_t  wake_q;
  ltmc_wake_t  wake_d;
  logic [31:0] wake_cnt_q;
  logic [31:0] txto_cnt_q;
  logic        pullup_q;

  wire wr_ctrl = reg_wr && (reg_addr == LTMC_CTRL_OFS);
  wire wr_wake = reg_wr && (reg_addr == LTMC_WAKE_OFS);
  wire rd_ctrl = reg_addr == LTMC_CTRL_OFS;
  wire rd_stat = reg_addr == LTMC_STAT_OFS;
  wire rd_wake = reg_addr == LTMC_WAKE_OFS;

  wire [7:0] ctrl_view = {6'h00, lin_mode_select_q};
  wire [7:0] stat_view = {6'h00, tx_timeout_flag_q,
                          transceiver_ready_flag_q};
  wire [7:0] wake_view = {6'h00, bus_wake_flag_q, bus_wake_enable_q};
  wire [7:0] rd_mux    = rd_ctrl ? ctrl_view :
                         rd_stat ? stat_view :
                         rd_wake ? wake_view : 8'h00;

  // software owns the select field; hardware only reads it
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      lin_mode_select_q <= LTMC_CTRL_RST[1:0];
    else if (wr_ctrl)
      lin_mode_select_q <= reg_wdata[LTMC_MODE_LSB +: 2];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      bus_wake_enable_q <= 1'b0;
    else if (wr_wake)
      bus_wake_enable_q <= reg_wdata[LTMC_WKEN_BIT];
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      rdata_q <= 8'h00;
    else if (reg_rd)
      rdata_q <= rd_mux;
    else
      rdata_q <= 8'h00;
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // transceiver mode state machine
  // ----------------------------------------------------------------
  // only code 10 asks for normal; 00 and 11 read as standby
  wire sel_normal = lin_mode_select_q == LTMC_SEL_NORM;
  wire any_uv     = supply.vs_uv || supply.vcc_uv;
  wire go_normal  = supply.chip_normal && !any_uv && !supply.overtemp
                    && sel_normal;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      LTMC_UNPOWERED:
        if (supply.vs_above_pwron)
          state_d = LTMC_STANDBY;
      LTMC_STANDBY:
        if (supply.vs_below_pwroff)
          state_d = LTMC_UNPOWERED;
        else if (go_normal)
          state_d = LTMC_NORMAL;
      LTMC_NORMAL:
        if (!go_normal)
          state_d = LTMC_STANDBY;
      default:
        state_d = LTMC_STANDBY;
    endcase
  end

  // after power-on reset the first stop is unpowered, then standby
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= LTMC_UNPOWERED;
    else
      state_q <= state_d;
  end

  wire in_normal  = state_q == LTMC_NORMAL;
  wire in_standby = state_q == LTMC_STANDBY;

  // ----------------------------------------------------------------
  // bus wake detection
  // ----------------------------------------------------------------
  wire wake_allowed = in_standby && bus_wake_enable_q
                      && !supply.overtemp
                      && !supply.vs_uv;
  wire cnt_done     = wake_cnt_q >= 32'(TBUS_CYC - 1);
  wire wake_event   = (wake_q == LTMC_W_ARMED) && !bus_below_prewake
                      && wake_allowed;

  always_comb
  begin
    wake_d = wake_q;
    unique case (wake_q)
      LTMC_W_IDLE:
        if (wake_allowed && bus_below_prewake)
          wake_d = LTMC_W_TIMING;
      LTMC_W_TIMING:
        if (!wake_allowed || !bus_below_prewake)
          wake_d = LTMC_W_IDLE;
        else if (cnt_done)
          wake_d = LTMC_W_ARMED;
      LTMC_W_ARMED:
        if (!wake_allowed || !bus_below_prewake)
          wake_d = LTMC_W_IDLE;
      default:
        wake_d = LTMC_W_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wake_q <= LTMC_W_IDLE;
    else
      wake_q <= wake_d;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      wake_cnt_q <= 32'h0000_0000;
    else if (wake_q == LTMC_W_TIMING && !cnt_done)
      wake_cnt_q <= wake_cnt_q + 32'h0000_0001;
    else if (wake_q != LTMC_W_TIMING)
      wake_cnt_q <= 32'h0000_0000;
  end

  // dominant longer than the filter time then release sets the flag
  wire wake_clr = wr_wake && reg_wdata[LTMC_WKFL_BIT];
  assign bus_wake_flag_d = wake_event ? 1'b1 :
                           wake_clr   ? 1'b0 :
                           bus_wake_flag_q;

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      bus_wake_flag_q <= 1'b0;
    else
      bus_wake_flag_q <= bus_wake_flag_d;
  end

  // pull-up stays on until standby with the flag cleared and wake detection idle
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      pullup_q <= 1'b0;
    else if (wake_allowed && bus_below_prewake)
      pullup_q <= 1'b1;
    else if (in_standby && !bus_wake_flag_q && wake_q == LTMC_W_IDLE)
      pullup_q <= 1'b0;
  end

  assign strong_pullup_en = pullup_q;
  assign wake_rx_en       = wake_q != LTMC_W_IDLE;

  // ----------------------------------------------------------------
  // transmit dominant time-out
  // ----------------------------------------------------------------
  wire txto_hit = txto_cnt_q >= 32'(TXTO_CYC - 1);

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      txto_cnt_q <= 32'h0000_0000;
    else if (!in_normal || txd_in)
      txto_cnt_q <= 32'h0000_0000;
    else if (!txto_hit)
      txto_cnt_q <= txto_cnt_q + 32'h0000_0001;
  end

  // latched until the transmit input returns recessive or the state leaves normal
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      tx_timeout_flag_q <= 1'b0;
    else if (!in_normal || txd_in)
      tx_timeout_flag_q <= 1'b0;
    else if (txto_hit)
      tx_timeout_flag_q <= 1'b1;
  end

  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
      transceiver_ready_flag_q <= 1'b0;
    else
      transceiver_ready_flag_q <= in_normal && !tx_timeout_flag_q;
  end

  // ----------------------------------------------------------------
  // pin outputs
  // ----------------------------------------------------------------
  // bus communication only in normal
  assign lin_drive_dominant = in_normal && !tx_timeout_flag_q && !txd_in;
  assign termination_en     = in_normal;
  assign transceiver_normal = in_normal;

  // standby: receive output low flags a pending wake
  assign rxd_out = in_normal  ? bus_rx_level :
                   in_standby ? !bus_wake_flag_q : 1'b1;

endmodule

`default_nettype wire

// [ltmc_core_asserts.sv]
// ltmc_core_asserts: port checks of ltmc_core
// assumes one clock domain, bound to every ltmc_core
`timescale 1ns/1ns
`default_nettype none
module ltmc_core_asserts
  import ltmc_pkg::*;
#(
  parameter int TXTO_CYC = 16
)
(
  input wire logic         clock,
  input wire logic         reset_n,
  input wire logic [7:0]   reg_addr,
  input wire logic [7:0]   reg_wdata,
  input wire logic         reg_wr,
  input wire logic         reg_rd,
  input wire logic [7:0]   reg_rdata,
  input wire ltmc_supply_t supply,
  input wire logic         bus_below_prewake,
  input wire logic         txd_in,
  input wire logic         rxd_out,
  input wire logic         lin_drive_dominant,
  input wire logic         strong_pullup_en,
  input wire logic         wake_rx_en,
  input wire logic         transceiver_normal
);
  logic [1:0] mode_q;
  logic       wen_q;
  logic       pw_q;
  int         tcnt_q;
  wire        ok_sup = supply.chip_normal && !supply.vs_uv
                    && !supply.vcc_uv && !supply.overtemp;
  wire        go = ok_sup && mode_q == LTMC_SEL_NORM;
  wire        stby = pw_q && !supply.vs_below_pwroff && !transceiver_normal;
  always_ff @(posedge clock or negedge reset_n)
    if (!reset_n)
    begin
      mode_q <= LTMC_SEL_STBY;
      wen_q  <= 1'b0;
      pw_q   <= 1'b0;
      tcnt_q <= 0;
    end
    else
    begin
      if (reg_wr && reg_addr == LTMC_CTRL_OFS)
        mode_q <= reg_wdata[1:0];
      if (reg_wr && reg_addr == LTMC_WAKE_OFS)
        wen_q <= reg_wdata[0];
      pw_q   <= supply.vs_above_pwron || (pw_q && !supply.vs_below_pwroff);
      tcnt_q <= (transceiver_normal && !txd_in) ? tcnt_q + 1 : 0;
    end
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);
  AST_STAY_STBY: assert property (!go |=> !transceiver_normal)
    else $error("normal without all conditions");
  AST_GO_NORM: assert property (go && stby |=> transceiver_normal)
    else $error("normal not entered");
  AST_NO_WAKE_NORM: assert property
    (transceiver_normal && $past(transceiver_normal) |-> !wake_rx_en)
    else $error("wake detection active in normal");
  AST_OT_NO_WAKE: assert property
    (supply.overtemp && !wake_rx_en |=> !wake_rx_en)
    else $error("wake started in overtemperature");
  AST_UV_NO_WAKE: assert property
    (supply.vs_uv && !wake_rx_en |=> !wake_rx_en)
    else $error("wake started in undervoltage");
  AST_WAKE_START: assert property
    (stby && !go && wen_q && bus_below_prewake
    && !supply.overtemp && !supply.vs_uv && !wake_rx_en
    |=> wake_rx_en && strong_pullup_en)
    else $error("wake detection not started");
  AST_FLAG_PULLUP: assert property
    (!transceiver_normal && !rxd_out |-> strong_pullup_en)
    else $error("pull-up off while wake flagged");
  AST_DRV: assert property
    (lin_drive_dominant |-> transceiver_normal && !txd_in)
    else $error("driver on outside normal transmit");
  AST_TXTO: assert property (tcnt_q > TXTO_CYC |-> !lin_drive_dominant)
    else $error("driver on after transmit time-out");
  AST_CTRL_RD: assert property
    ($past(reg_rd) && $past(reg_addr) == LTMC_CTRL_OFS
    |-> reg_rdata == {6'h00, mode_q})
    else $error("control read mismatch");
  AST_STAT_RD: assert property
    ($past(reg_rd) && $past(reg_addr) == LTMC_STAT_OFS |-> reg_rdata[7:2] == 6'h00)
    else $error("status reserved bits set");
  cover property ($rose(transceiver_normal));
  cover property ($fell(rxd_out) && !transceiver_normal);
  cover property (tcnt_q > TXTO_CYC);
endmodule
bind ltmc_core ltmc_core_asserts #(.TXTO_CYC(TXTO_CYC)) u_chk (.*);
`default_nettype wire

// [ltmc_bus_model.sv]
// ltmc_bus_model: lin wire with pull-up, remote node and our driver
// assumes remote_dom comes from the bench
`timescale 1ns/1ns
`default_nettype none
module ltmc_bus_model
(
  input  wire logic drive_dom,
  input  wire logic remote_dom,
  output logic      bus_below_prewake,
  output logic      bus_rx_level
);
  // wired-and: any node pulls dominant, else pull-up recessive
  assign bus_below_prewake = drive_dom | remote_dom;
  assign bus_rx_level      = ~(drive_dom | remote_dom);
endmodule
`default_nettype wire

// [lin_transceiver_mode_control_tb.sv]
// lin_transceiver_mode_control_tb: scenarios of ltmc_core
// assumes short counts: TBUS_CYC 8, TXTO_CYC 16
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin error_cnt++; \
  $display("unexpected at %0t: got %0h", $time, a); end end
module lin_transceiver_mode_control_tb
  import ltmc_pkg::*;
;
  logic clock = 0, reset_n = 0, reg_wr = 0, reg_rd = 0, txd_in = 1, rem = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  ltmc_supply_t sup = '0;
  logic [7:0] reg_rdata;
  logic bbp, brx, rxd, drv, pu, wrx, nrm, trm;
  int error_cnt = 0, check_count = 0, cyc = 0;
  always #2 clock = ~clock;
  ltmc_core #(.TBUS_CYC(8), .TXTO_CYC(16)) u_dut (.clock(clock),
    .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .supply(sup),
    .bus_below_prewake(bbp), .bus_rx_level(brx), .txd_in(txd_in),
    .rxd_out(rxd), .lin_drive_dominant(drv), .termination_en(trm),
    .strong_pullup_en(pu), .wake_rx_en(wrx), .transceiver_normal(nrm));
  ltmc_bus_model u_bus (.drive_dom(drv), .remote_dom(rem),
    .bus_below_prewake(bbp), .bus_rx_level(brx));
  task tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 `CHK(reg_rdata, e)
  endtask
  task t_power;
    rd(LTMC_CTRL_OFS, LTMC_CTRL_RST);
    rd(LTMC_STAT_OFS, LTMC_STAT_RST);
    rd(8'h30, 8'h00);
    sup.chip_normal <= 1'b1;
    wr(LTMC_CTRL_OFS, 8'h02);
    tick(3);
    `CHK(nrm, 1'b0)
    sup.vs_above_pwron <= 1'b1;
    tick(3);
    `CHK(nrm, 1'b1)
    `CHK(trm, 1'b1)
    rd(LTMC_STAT_OFS, 8'h01);
    rd(LTMC_CTRL_OFS, 8'h02);
  endtask
  task t_modes;
    logic [1:0] c [3] = '{2'h1, 2'h0, 2'h3};
    for (int k = 0; k < 4; k++)
    begin
      sup[k] <= ~sup[k];
      tick(2);
      `CHK(nrm, 1'b0)
      sup[k] <= ~sup[k];
      tick(2);
      `CHK(nrm, 1'b1)
    end
    foreach (c[i])
    begin
      wr(LTMC_CTRL_OFS, {6'h00, c[i]});
      tick(2);
      `CHK(nrm, 1'b0)
      wr(LTMC_CTRL_OFS, 8'h02);
      tick(2);
    end
  endtask
  task t_timeout;
    txd_in <= 1'b0;
    tick(2);
    `CHK({drv, rxd}, 2'b10)
    tick(20);
    `CHK(drv, 1'b0)
    rd(LTMC_STAT_OFS, 8'h02);
    txd_in <= 1'b1;
    tick(3);
    rd(LTMC_STAT_OFS, 8'h01);
  endtask
  task t_wake;
    wr(LTMC_WAKE_OFS, 8'h01);
    rem <= 1'b1;
    tick(3);
    `CHK(wrx, 1'b0)
    rem <= 1'b0;
    for (int k = 1; k < 4; k += 2)
    begin
      sup[k] <= 1'b1;
      rem <= 1'b1;
      tick(3);
      `CHK(wrx, 1'b0)
      rem <= 1'b0;
      sup[k] <= 1'b0;
      tick(1);
    end
    wr(LTMC_CTRL_OFS, 8'h01);
    rem <= 1'b1;
    tick(2);
    `CHK({wrx, pu}, 2'b11)
    tick(4);
    rem <= 1'b0;
    tick(2);
    rd(LTMC_WAKE_OFS, 8'h01);
    rem <= 1'b1;
    tick(12);
    rem <= 1'b0;
    tick(2);
    `CHK(rxd, 1'b0)
    rd(LTMC_WAKE_OFS, 8'h03);
    `CHK(pu, 1'b1)
    wr(LTMC_WAKE_OFS, 8'h03);
    tick(3);
    `CHK({pu, rxd}, 2'b01)
  endtask
  task t_unpower;
    sup.vs_above_pwron <= 1'b0;
    sup.vs_below_pwroff <= 1'b1;
    wr(LTMC_CTRL_OFS, 8'h02);
    tick(3);
    `CHK({nrm, rxd}, 2'b01)
    `CHK(trm, 1'b0)
  endtask
  task final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      final_report;
    end
  end
  initial
  begin
    tick(5);
    reset_n <= 1'b1;
    t_power;
    t_modes;
    t_timeout;
    t_wake;
    t_unpower;
    final_report;
  end
endmodule
`default_nettype wire
